// >>> design/ssr_event_stage.sv
// one condition / transition filter / event latch slice per status register
// assumes condition inputs are already masked and synchronous to core_clk_i
`timescale 1ns/1ps
module ssr_event_stage (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] cond_i,
  input wire logic [15:0] ptr_i,
  input wire logic [15:0] ntr_i,
  input wire logic clear_i,
  output logic [15:0] event_o
);

  typedef struct packed {
    logic [15:0] cond_prev;
    logic [15:0] events;
  } ssr_stage_st_t;

  ssr_stage_st_t st_reg;
  ssr_stage_st_t st_next;

  // filter selects edges; both filters set gives either direction
  always_comb begin
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] hit;
    rise = cond_i & ~st_reg.cond_prev;
    fall = ~cond_i & st_reg.cond_prev;
    hit = (rise & ptr_i) | (fall & ntr_i);
    st_next = st_reg;
    st_next.cond_prev = cond_i;
    // new edges win over a clear in the same cycle so no event is lost
    if (clear_i) begin
      st_next.events = hit;
    end else begin
      st_next.events = st_reg.events | hit;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign event_o = st_reg.events;

endmodule : ssr_event_stage

// >>> design/ssr_pkg.sv
// status reporting package: command codes, carriers, masks and preset values
// assumes one synchronous clock domain and a decoded command stream from the text parser
package ssr_pkg;

  localparam int unsigned STAT_W = 16;
  localparam int unsigned NUM_REGS = 4;

  // register index: operation plus the three module status registers
  localparam logic [1:0] IDX_OPER = 2'h0;
  localparam logic [1:0] IDX_SYNTH = 2'h1;
  localparam logic [1:0] IDX_PATGEN = 2'h2;
  localparam logic [1:0] IDX_ERRDET = 2'h3;

  // module numbers carried by the module select command
  localparam logic [15:0] MODNUM_SYNTH = 16'h0001;
  localparam logic [15:0] MODNUM_PATGEN = 16'h0002;
  localparam logic [15:0] MODNUM_ERRDET = 16'h0003;

  // operation activity bit positions
  localparam int unsigned OPER_BATHTUB_BIT = 3;
  localparam int unsigned OPER_MEAS_BIT = 4;
  localparam int unsigned OPER_AUTO_ADJ_BIT = 7;
  localparam int unsigned OPER_AUTO_SEARCH_BIT = 8;
  localparam int unsigned OPER_EYE_MARGIN_BIT = 9;
  localparam int unsigned OPER_EYE_CONTOUR_BIT = 10;
  localparam int unsigned OPER_PAT_LOAD_BIT = 11;
  localparam int unsigned OPER_INIT_BIT = 12;

  // synthesizer bit
  localparam int unsigned SYN_PLL_UNLOCK_BIT = 0;

  // error detector bits
  localparam int unsigned ED_INSERT_ERR_BIT = 0;
  localparam int unsigned ED_OMIT_ERR_BIT = 1;
  localparam int unsigned ED_TOTAL_ERR_BIT = 2;
  localparam int unsigned ED_SYNC_LOSS_BIT = 4;
  localparam int unsigned ED_CLK_LOSS_BIT = 5;
  localparam int unsigned ED_DELAY_BUSY_BIT = 6;
  localparam int unsigned ED_TRANS_ERR_BIT = 8;
  localparam int unsigned ED_NONTRANS_ERR_BIT = 9;
  localparam int unsigned ED_CR_UNLOCK_BIT = 10;
  localparam int unsigned ED_DELAY_CAL_BIT = 11;

  // pattern generator bits
  localparam int unsigned PG_CMU_UNLOCK_BIT = 1;
  localparam int unsigned PG_DELAY_BUSY_BIT = 2;
  localparam int unsigned PG_DELAY_CAL_BIT = 4;

  // implemented-bit masks, built from the positions above
  localparam logic [15:0] OPER_MASK = 16'h0001 << OPER_BATHTUB_BIT
    | 16'h0001 << OPER_MEAS_BIT | 16'h0001 << OPER_AUTO_ADJ_BIT
    | 16'h0001 << OPER_AUTO_SEARCH_BIT | 16'h0001 << OPER_EYE_MARGIN_BIT
    | 16'h0001 << OPER_EYE_CONTOUR_BIT | 16'h0001 << OPER_PAT_LOAD_BIT
    | 16'h0001 << OPER_INIT_BIT;
  localparam logic [15:0] SYN_MASK = 16'h0001 << SYN_PLL_UNLOCK_BIT;
  localparam logic [15:0] ED_MASK = 16'h0001 << ED_INSERT_ERR_BIT
    | 16'h0001 << ED_OMIT_ERR_BIT | 16'h0001 << ED_TOTAL_ERR_BIT
    | 16'h0001 << ED_SYNC_LOSS_BIT | 16'h0001 << ED_CLK_LOSS_BIT
    | 16'h0001 << ED_DELAY_BUSY_BIT | 16'h0001 << ED_TRANS_ERR_BIT
    | 16'h0001 << ED_NONTRANS_ERR_BIT | 16'h0001 << ED_CR_UNLOCK_BIT
    | 16'h0001 << ED_DELAY_CAL_BIT;
  localparam logic [15:0] PG_MASK = 16'h0001 << PG_CMU_UNLOCK_BIT
    | 16'h0001 << PG_DELAY_BUSY_BIT | 16'h0001 << PG_DELAY_CAL_BIT;

  // values after power-on and preset; clear-status restores the filter values only
  localparam logic [15:0] ENABLE_PRESET = 16'h0000;
  localparam logic [15:0] PTR_PRESET = 16'hFFFF;
  localparam logic [15:0] NTR_PRESET = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_UNIT_SELECT,
    OP_MODULE_SELECT,
    OP_PORT_SELECT,
    OP_PRESET,
    OP_CLEAR_STATUS,
    OP_OPER_EVENT_Q,
    OP_OPER_COND_Q,
    OP_OPER_ENABLE_W,
    OP_OPER_ENABLE_Q,
    OP_OPER_PTR_W,
    OP_OPER_NTR_W,
    OP_OPER_PTR_Q,
    OP_OPER_NTR_Q,
    OP_MOD_EVENT_Q,
    OP_MOD_COND_Q,
    OP_MOD_PTR_W,
    OP_MOD_NTR_W,
    OP_MOD_PTR_Q,
    OP_MOD_NTR_Q
  } ssr_op_t;

  typedef struct packed {
    logic valid;
    ssr_op_t op;
    logic [15:0] data;
  } ssr_cmd_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } ssr_resp_t;

  localparam ssr_resp_t RESP_IDLE = '{valid: 1'b0, err: 1'b0, data: 16'h0000};

endpackage : ssr_pkg

// >>> design/ssr_status_top.sv
// status reporting top: operation and per-module status registers behind a command port
// assumes a text parser delivers decoded commands one cycle each and takes answers as pulses
`timescale 1ns/1ps
module ssr_status_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ssr_pkg::ssr_cmd_t cmd_i,
  input wire logic bathtub_run_i,
  input wire logic meas_run_i,
  input wire logic auto_adjust_run_i,
  input wire logic auto_search_run_i,
  input wire logic eye_margin_run_i,
  input wire logic eye_contour_run_i,
  input wire logic pattern_load_run_i,
  input wire logic init_run_i,
  input wire logic pll_unlock_i,
  input wire logic cmu_unlock_i,
  input wire logic pg_delay_busy_i,
  input wire logic pg_delay_cal_req_i,
  input wire logic insert_err_i,
  input wire logic omit_err_i,
  input wire logic total_err_i,
  input wire logic sync_loss_i,
  input wire logic clock_loss_i,
  input wire logic ed_delay_busy_i,
  input wire logic trans_err_i,
  input wire logic nontrans_err_i,
  input wire logic cr_unlock_i,
  input wire logic ed_delay_cal_req_i,
  output ssr_pkg::ssr_resp_t resp_o,
  output logic [1:0] sel_module_o,
  output logic sel_valid_o,
  output logic oper_summary_o
);

  typedef enum logic {
    SEQ_IDLE,
    SEQ_UNIT_SEEN
  } ssr_seq_t;

  typedef struct packed {
    ssr_seq_t seq;
    logic sel_valid;
    logic [1:0] sel_mod;
    logic [15:0] unit_num;
    logic [15:0] port_num;
    logic [15:0] oper_enable;
    logic [3:0][15:0] ptr;
    logic [3:0][15:0] ntr;
    logic summary;
    ssr_pkg::ssr_resp_t resp;
  } ssr_top_st_t;

  ssr_top_st_t st_reg;
  ssr_top_st_t st_next;

  logic [3:0][15:0] cond;
  logic [3:0][15:0] events;
  logic [3:0] clear;

  // map a module number to its register index; bit 2 flags an unknown number
  function automatic logic [2:0] mod_decode(input logic [15:0] num);
    logic [2:0] r;
    r = 3'b100;
    if (num == ssr_pkg::MODNUM_SYNTH) begin
      r = {1'b0, ssr_pkg::IDX_SYNTH};
    end else if (num == ssr_pkg::MODNUM_PATGEN) begin
      r = {1'b0, ssr_pkg::IDX_PATGEN};
    end else if (num == ssr_pkg::MODNUM_ERRDET) begin
      r = {1'b0, ssr_pkg::IDX_ERRDET};
    end
    return r;
  endfunction : mod_decode

  // build a one-cycle answer carrying a register value
  function automatic ssr_pkg::ssr_resp_t answer(input logic ok, input logic [15:0] v);
    ssr_pkg::ssr_resp_t r;
    r.valid = 1'b1;
    r.err = ~ok;
    r.data = ok ? v : ssr_pkg::ZERO16;
    return r;
  endfunction : answer

  // live condition bits, unimplemented positions held at zero
  always_comb begin
    cond = '0;
    // operation activity: high while the job runs
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_BATHTUB_BIT] = bathtub_run_i;
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_MEAS_BIT] = meas_run_i;
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_AUTO_ADJ_BIT] = auto_adjust_run_i;
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_AUTO_SEARCH_BIT] = auto_search_run_i;
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_EYE_MARGIN_BIT] = eye_margin_run_i;
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_EYE_CONTOUR_BIT] = eye_contour_run_i;
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_PAT_LOAD_BIT] = pattern_load_run_i;
    cond[ssr_pkg::IDX_OPER][ssr_pkg::OPER_INIT_BIT] = init_run_i;

    // synthesizer loop lock
    cond[ssr_pkg::IDX_SYNTH][ssr_pkg::SYN_PLL_UNLOCK_BIT] = pll_unlock_i;

    // pattern generator clock and delay state
    cond[ssr_pkg::IDX_PATGEN][ssr_pkg::PG_CMU_UNLOCK_BIT] = cmu_unlock_i;
    cond[ssr_pkg::IDX_PATGEN][ssr_pkg::PG_DELAY_BUSY_BIT] = pg_delay_busy_i;
    cond[ssr_pkg::IDX_PATGEN][ssr_pkg::PG_DELAY_CAL_BIT] = pg_delay_cal_req_i;

    // error detector: errors, losses and delay state
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_INSERT_ERR_BIT] = insert_err_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_OMIT_ERR_BIT] = omit_err_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_TOTAL_ERR_BIT] = total_err_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_SYNC_LOSS_BIT] = sync_loss_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_CLK_LOSS_BIT] = clock_loss_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_DELAY_BUSY_BIT] = ed_delay_busy_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_TRANS_ERR_BIT] = trans_err_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_NONTRANS_ERR_BIT] = nontrans_err_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_CR_UNLOCK_BIT] = cr_unlock_i;
    cond[ssr_pkg::IDX_ERRDET][ssr_pkg::ED_DELAY_CAL_BIT] = ed_delay_cal_req_i;
  end

  // read-clear strobes; a module read needs a live selection
  always_comb begin
    clear = '0;
    if (cmd_i.valid) begin
      unique case (cmd_i.op)
        ssr_pkg::OP_OPER_EVENT_Q: clear[ssr_pkg::IDX_OPER] = 1'b1;
        ssr_pkg::OP_MOD_EVENT_Q: clear[st_reg.sel_mod] = st_reg.sel_valid;
        ssr_pkg::OP_CLEAR_STATUS: clear = '1;
        default: clear = '0;
      endcase
    end
  end

  // one slice per register: edge filter and sticky event latch
  for (genvar g = 0; g < ssr_pkg::NUM_REGS; g++) begin : g_stage
    ssr_event_stage u_stage (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .cond_i(cond[g]),
      .ptr_i(st_reg.ptr[g]),
      .ntr_i(st_reg.ntr[g]),
      .clear_i(clear[g]),
      .event_o(events[g])
    );
  end

  // command decode; answers are registered so every port comes from a flop
  always_comb begin
    logic [2:0] dec;
    logic [1:0] m;
    logic sv;
    dec = mod_decode(cmd_i.data);
    m = st_reg.sel_mod;
    sv = st_reg.sel_valid;
    st_next = st_reg;
    st_next.resp = ssr_pkg::RESP_IDLE;
    st_next.summary = |(events[ssr_pkg::IDX_OPER] & st_reg.oper_enable);
    if (cmd_i.valid) begin
      unique case (cmd_i.op)
        // the unit number only opens the window for a module select
        ssr_pkg::OP_UNIT_SELECT: begin
          st_next.unit_num = cmd_i.data;
          st_next.seq = SEQ_UNIT_SEEN;
        end

        ssr_pkg::OP_MODULE_SELECT: begin
          // a module select without a preceding unit select is refused
          if (st_reg.seq == SEQ_UNIT_SEEN && !dec[2]) begin
            st_next.sel_mod = dec[1:0];
            st_next.sel_valid = 1'b1;
            st_next.seq = SEQ_IDLE;
          end else begin
            st_next.resp = answer(1'b0, ssr_pkg::ZERO16);
          end
        end

        // the port number is kept; it routes nothing in this block
        ssr_pkg::OP_PORT_SELECT: begin
          st_next.port_num = cmd_i.data;
        end

        // preset leaves module filters and event latches alone
        ssr_pkg::OP_PRESET: begin
          st_next.oper_enable = ssr_pkg::ENABLE_PRESET;
          st_next.ptr[ssr_pkg::IDX_OPER] = ssr_pkg::PTR_PRESET;
          st_next.ntr[ssr_pkg::IDX_OPER] = ssr_pkg::NTR_PRESET;
        end

        ssr_pkg::OP_CLEAR_STATUS: begin
          // clear-status also returns every filter to its preset value
          st_next.ptr = {ssr_pkg::NUM_REGS{ssr_pkg::PTR_PRESET}};
          st_next.ntr = {ssr_pkg::NUM_REGS{ssr_pkg::NTR_PRESET}};
        end

        // answer and read-clear share one edge
        ssr_pkg::OP_OPER_EVENT_Q: begin
          st_next.resp = answer(1'b1, events[ssr_pkg::IDX_OPER]);
        end
        ssr_pkg::OP_OPER_COND_Q: begin
          st_next.resp = answer(1'b1, cond[ssr_pkg::IDX_OPER]);
        end

        // enable keeps implemented bits only; filters keep all 16
        ssr_pkg::OP_OPER_ENABLE_W: begin
          st_next.oper_enable = cmd_i.data & ssr_pkg::OPER_MASK;
        end
        ssr_pkg::OP_OPER_ENABLE_Q: begin
          st_next.resp = answer(1'b1, st_reg.oper_enable);
        end
        ssr_pkg::OP_OPER_PTR_W: begin
          st_next.ptr[ssr_pkg::IDX_OPER] = cmd_i.data;
        end
        ssr_pkg::OP_OPER_NTR_W: begin
          st_next.ntr[ssr_pkg::IDX_OPER] = cmd_i.data;
        end

        // filter answers show implemented bits only
        ssr_pkg::OP_OPER_PTR_Q: begin
          st_next.resp = answer(1'b1, st_reg.ptr[ssr_pkg::IDX_OPER] & ssr_pkg::OPER_MASK);
        end
        ssr_pkg::OP_OPER_NTR_Q: begin
          st_next.resp = answer(1'b1, st_reg.ntr[ssr_pkg::IDX_OPER] & ssr_pkg::OPER_MASK);
        end

        // module commands act on the selected module only
        ssr_pkg::OP_MOD_EVENT_Q: begin
          st_next.resp = answer(sv, events[m]);
        end
        ssr_pkg::OP_MOD_COND_Q: begin
          st_next.resp = answer(sv, cond[m]);
        end

        ssr_pkg::OP_MOD_PTR_W: begin
          if (sv) begin
            st_next.ptr[m] = cmd_i.data;
          end else begin
            st_next.resp = answer(1'b0, ssr_pkg::ZERO16);
          end
        end

        ssr_pkg::OP_MOD_NTR_W: begin
          if (sv) begin
            st_next.ntr[m] = cmd_i.data;
          end else begin
            st_next.resp = answer(1'b0, ssr_pkg::ZERO16);
          end
        end

        // module filter answers come back unmasked
        ssr_pkg::OP_MOD_PTR_Q: begin
          st_next.resp = answer(sv, st_reg.ptr[m]);
        end
        ssr_pkg::OP_MOD_NTR_Q: begin
          st_next.resp = answer(sv, st_reg.ntr[m]);
        end

        // codes past the last command are ignored
        default: begin
          st_next.resp = ssr_pkg::RESP_IDLE;
        end
      endcase
    end
  end

  // power-on loads the preset values into the enable and every filter: filters rising-only, enable masked
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg.seq <= SEQ_IDLE;
      st_reg.sel_valid <= 1'b0;
      st_reg.sel_mod <= 2'h0;
      st_reg.unit_num <= ssr_pkg::ZERO16;
      st_reg.port_num <= ssr_pkg::ZERO16;
      st_reg.oper_enable <= ssr_pkg::ENABLE_PRESET;
      st_reg.ptr <= {ssr_pkg::NUM_REGS{ssr_pkg::PTR_PRESET}};
      st_reg.ntr <= {ssr_pkg::NUM_REGS{ssr_pkg::NTR_PRESET}};
      st_reg.summary <= 1'b0;
      st_reg.resp <= ssr_pkg::RESP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // every port is a plain copy of a state flop
  assign resp_o = st_reg.resp;
  assign sel_module_o = st_reg.sel_mod;
  assign sel_valid_o = st_reg.sel_valid;
  assign oper_summary_o = st_reg.summary;

endmodule : ssr_status_top

// >>> testbench/ssr_host_model.sv
// host model: issues decoded status commands and picks up answers
// assumes the device answers one cycle after it takes a command
`timescale 1ns/1ps
module ssr_host_model (
  input wire logic core_clk_i,
  input wire ssr_pkg::ssr_resp_t resp_i,
  output ssr_pkg::ssr_cmd_t cmd_o
);
  initial cmd_o = '0;
  // hold one command over one edge, then read the settled answer
  task automatic issue(input ssr_pkg::ssr_op_t o, input logic [15:0] d,
    output ssr_pkg::ssr_resp_t a);
    cmd_o = '{valid: 1'b1, op: o, data: d};
    @(posedge core_clk_i);
    #1;
    a = resp_i;
  endtask : issue
  // released payload is inverted so a stale value cannot pass for a new one
  task automatic idle();
    cmd_o = '{valid: 1'b0, op: cmd_o.op, data: ~cmd_o.data};
    @(posedge core_clk_i);
    #1;
  endtask : idle
  // unit, module, then the optional port, back to back
  task automatic select(input logic [15:0] m, input logic port, output ssr_pkg::ssr_resp_t a);
    ssr_pkg::ssr_resp_t u;
    issue(ssr_pkg::OP_UNIT_SELECT, 16'h0001, u);
    issue(ssr_pkg::OP_MODULE_SELECT, m, a);
    if (port)
      issue(ssr_pkg::OP_PORT_SELECT, 16'h0001, u);
    idle();
  endtask : select
endmodule : ssr_host_model

// >>> testbench/ssr_status_chk.sv
// checker: answers, selection and preset seen at the status block ports
// assumes one clock domain; bound onto every ssr_status_top
`timescale 1ns/1ps
module ssr_status_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire ssr_pkg::ssr_cmd_t cmd_i,
  input wire logic bathtub_run_i,
  input wire logic meas_run_i,
  input wire logic auto_adjust_run_i,
  input wire logic auto_search_run_i,
  input wire logic eye_margin_run_i,
  input wire logic eye_contour_run_i,
  input wire logic pattern_load_run_i,
  input wire logic init_run_i,
  input wire ssr_pkg::ssr_resp_t resp_o,
  input wire logic [1:0] sel_module_o,
  input wire logic sel_valid_o
);
  logic armed_reg;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // live operation condition at its weights
  wire logic [15:0] cv = {3'h0, init_run_i, pattern_load_run_i, eye_contour_run_i,
    eye_margin_run_i, auto_search_run_i, auto_adjust_run_i, 2'h0, meas_run_i,
    bathtub_run_i, 3'h0};
  // decoded command strobes
  wire logic evq = cmd_i.valid && cmd_i.op == ssr_pkg::OP_OPER_EVENT_Q;
  wire logic cq = cmd_i.valid && cmd_i.op == ssr_pkg::OP_OPER_COND_Q;
  wire logic enq = cmd_i.valid && cmd_i.op == ssr_pkg::OP_OPER_ENABLE_Q;
  wire logic prq = cmd_i.valid && cmd_i.op == ssr_pkg::OP_PRESET;
  wire logic unq = cmd_i.valid && cmd_i.op == ssr_pkg::OP_UNIT_SELECT;
  wire logic msq = cmd_i.valid && cmd_i.op == ssr_pkg::OP_MODULE_SELECT;
  wire logic mdq = cmd_i.valid && cmd_i.op >= ssr_pkg::OP_MOD_EVENT_Q;
  // first edge after reset compares with reset-time history, so skip it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i)
      armed_reg <= 1'b0;
    else
      armed_reg <= 1'b1;
  end
  sequence s_two_reads;
    armed_reg && evq && $stable(cv) ##1 evq;
  endsequence
  sequence s_selection;
    unq ##1 msq && cmd_i.data inside {16'h0001, 16'h0002, 16'h0003};
  endsequence
  sequence s_preset_read;
    prq ##1 enq;
  endsequence
  property p_cond;
    cq |=> resp_o.valid && !resp_o.err && resp_o.data == $past(cv);
  endproperty
  a_cond: assert property (p_cond) else $error("condition answer wrong");
  property p_evr;
    evq |=> resp_o.valid && (resp_o.data & 16'hE067) == 16'h0000;
  endproperty
  a_evr: assert property (p_evr) else $error("event answer out of range");
  property p_rdc;
    s_two_reads |=> resp_o.valid && resp_o.data == 16'h0000;
  endproperty
  a_rdc: assert property (p_rdc) else $error("event read did not clear");
  property p_hold;
    !msq |=> $stable(sel_module_o) && $stable(sel_valid_o);
  endproperty
  a_hold: assert property (p_hold) else $error("selection moved");
  property p_sel;
    s_selection |=> sel_valid_o && {14'h0000, sel_module_o} == $past(cmd_i.data);
  endproperty
  a_sel: assert property (p_sel) else $error("selection not taken");
  property p_ref;
    mdq && !sel_valid_o |=> resp_o.valid && resp_o.err && resp_o.data == 16'h0000;
  endproperty
  a_ref: assert property (p_ref) else $error("unselected access not refused");
  property p_pre;
    s_preset_read |=> resp_o.valid && resp_o.data == 16'h0000;
  endproperty
  a_pre: assert property (p_pre) else $error("enable not cleared by preset");
  property p_quiet;
    prq |=> !resp_o.valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("preset answered");
endmodule : ssr_status_chk
bind ssr_status_top ssr_status_chk ssr_status_chk_i (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .cmd_i(cmd_i), .bathtub_run_i(bathtub_run_i), .meas_run_i(meas_run_i),
  .auto_adjust_run_i(auto_adjust_run_i), .auto_search_run_i(auto_search_run_i),
  .eye_margin_run_i(eye_margin_run_i), .eye_contour_run_i(eye_contour_run_i),
  .pattern_load_run_i(pattern_load_run_i), .init_run_i(init_run_i), .resp_o(resp_o),
  .sel_module_o(sel_module_o), .sel_valid_o(sel_valid_o));

// >>> testbench/test_status_event_register_model.sv
// testbench: drives status inputs and host commands, compares answers
// assumes the host model moves its signals one ns after a rising edge
`timescale 1ns/1ps
module test_status_event_register_model;
  localparam logic [15:0] OPM = 16'h1F98; // bits 3, 4 and 7 to 12
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] op_in = 16'h0000, syn_in = 16'h0000, pg_in = 16'h0000, ed_in = 16'h0000;
  ssr_pkg::ssr_cmd_t cmd;
  ssr_pkg::ssr_resp_t resp, r;
  logic [1:0] sel_module;
  logic sel_valid, summary;
  int miscompares = 0, checks_done = 0;
  int unsigned obit[8] = '{3, 4, 7, 8, 9, 10, 11, 12};
  int unsigned ebit[10] = '{0, 1, 2, 4, 5, 6, 8, 9, 10, 11};
  int unsigned pbit[3] = '{1, 2, 4};
  always #5 core_clk = ~core_clk;
  ssr_host_model host (.core_clk_i(core_clk), .resp_i(resp), .cmd_o(cmd));
  // status inputs wired at their documented bit positions
  ssr_status_top ssr_status_top_i (
    .core_clk_i(core_clk), .rst_i(rst), .cmd_i(cmd), .resp_o(resp),
    .sel_module_o(sel_module), .sel_valid_o(sel_valid), .oper_summary_o(summary),
    .bathtub_run_i(op_in[3]), .meas_run_i(op_in[4]), .auto_adjust_run_i(op_in[7]),
    .auto_search_run_i(op_in[8]), .eye_margin_run_i(op_in[9]),
    .eye_contour_run_i(op_in[10]), .pattern_load_run_i(op_in[11]), .init_run_i(op_in[12]),
    .pll_unlock_i(syn_in[0]), .cmu_unlock_i(pg_in[1]), .pg_delay_busy_i(pg_in[2]),
    .pg_delay_cal_req_i(pg_in[4]), .insert_err_i(ed_in[0]), .omit_err_i(ed_in[1]),
    .total_err_i(ed_in[2]), .sync_loss_i(ed_in[4]), .clock_loss_i(ed_in[5]),
    .ed_delay_busy_i(ed_in[6]), .trans_err_i(ed_in[8]), .nontrans_err_i(ed_in[9]),
    .cr_unlock_i(ed_in[10]), .ed_delay_cal_req_i(ed_in[11]));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  // one command; flags 10 answer, 11 refused, 00 silent
  task automatic ask(input ssr_pkg::ssr_op_t o, input logic [15:0] d, input logic [15:0] e,
    input logic [1:0] f, input string nm);
    ssr_pkg::ssr_resp_t a;
    host.issue(o, d, a);
    host.idle();
    check({nm, " flags"}, {14'h0000, a.valid, a.err}, {14'h0000, f});
    if (f != 2'b00)
      check(nm, a.data, e);
  endtask : ask
  // cut a hung run short
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check("selection", {13'h0000, sel_valid, sel_module}, 16'h0000);
    // preset must undo earlier enable and filter writes
    ask(ssr_pkg::OP_OPER_ENABLE_W, 16'h0010, 16'h0000, 2'b00, "enable write");
    ask(ssr_pkg::OP_OPER_ENABLE_Q, 16'h0000, 16'h0010, 2'b10, "enable");
    ask(ssr_pkg::OP_OPER_PTR_W, 16'h0000, 16'h0000, 2'b00, "rise write");
    ask(ssr_pkg::OP_OPER_NTR_W, 16'hFFFF, 16'h0000, 2'b00, "fall write");
    host.issue(ssr_pkg::OP_PRESET, 16'h0000, r);
    host.issue(ssr_pkg::OP_OPER_ENABLE_Q, 16'h0000, r);
    host.idle();
    check("preset enable", r.data, 16'h0000);
    ask(ssr_pkg::OP_OPER_PTR_Q, 16'h0000, OPM, 2'b10, "preset rise");
    ask(ssr_pkg::OP_OPER_NTR_Q, 16'h0000, 16'h0000, 2'b10, "preset fall");
    // each activity input shows alone at its own weight
    foreach (obit[i]) begin
      op_in = 16'h0001 << obit[i];
      ask(ssr_pkg::OP_OPER_COND_Q, 16'h0000, op_in, 2'b10, "condition");
    end
    op_in = 16'h0000;
    tick();
    ask(ssr_pkg::OP_OPER_COND_Q, 16'h0000, 16'h0000, 2'b10, "condition");
    // every bit rose once; a read right behind the first finds nothing
    host.issue(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, r);
    check("events", r.data, OPM);
    host.issue(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, r);
    host.idle();
    check("events reread", r.data, 16'h0000);
    // repeated pulses leave one latched bit after the input fell
    repeat (2) begin
      op_in[4] = 1'b1;
      tick();
      op_in[4] = 1'b0;
      tick();
    end
    ask(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, 16'h0010, 2'b10, "held event");
    ask(ssr_pkg::OP_OPER_PTR_W, 16'h0000, 16'h0000, 2'b00, "rise write");
    ask(ssr_pkg::OP_OPER_NTR_W, OPM, 16'h0000, 2'b00, "fall write");
    op_in[8] = 1'b1;
    tick();
    ask(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, 16'h0000, 2'b10, "fall filter rise");
    op_in[8] = 1'b0;
    tick();
    ask(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, 16'h0100, 2'b10, "fall filter fall");
    ask(ssr_pkg::OP_OPER_PTR_W, OPM, 16'h0000, 2'b00, "rise write");
    op_in[9] = 1'b1;
    tick();
    ask(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, 16'h0200, 2'b10, "both rise");
    op_in[9] = 1'b0;
    tick();
    ask(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, 16'h0200, 2'b10, "both fall");
    op_in[3] = 1'b1;
    tick();
    // an enabled latched event raises the summary one cycle later
    ask(ssr_pkg::OP_OPER_ENABLE_W, 16'h0008, 16'h0000, 2'b00, "enable write");
    check("summary", {15'h0000, summary}, 16'h0001);
    ask(ssr_pkg::OP_CLEAR_STATUS, 16'h0000, 16'h0000, 2'b00, "clear");
    check("summary", {15'h0000, summary}, 16'h0000);
    ask(ssr_pkg::OP_OPER_EVENT_Q, 16'h0000, 16'h0000, 2'b10, "after clear");
    // module registers: refused until selected, then routed to the chosen one
    ask(ssr_pkg::OP_MOD_COND_Q, 16'h0000, 16'h0000, 2'b11, "no module");
    host.select(16'h0003, 1'b1, r);
    check("select flags", {14'h0000, r.valid, r.err}, 16'h0000);
    check("selection", {13'h0000, sel_valid, sel_module}, 16'h0007);
    foreach (ebit[i]) begin
      ed_in = 16'h0001 << ebit[i];
      ask(ssr_pkg::OP_MOD_COND_Q, 16'h0000, ed_in, 2'b10, "detector");
    end
    ask(ssr_pkg::OP_MODULE_SELECT, 16'h0002, 16'h0000, 2'b11, "bare select");
    host.select(16'h0009, 1'b0, r);
    check("unknown module", {14'h0000, r.valid, r.err}, 16'h0003);
    check("selection", {13'h0000, sel_valid, sel_module}, 16'h0007);
    host.select(16'h0002, 1'b0, r);
    ed_in = 16'h0F77; // must not leak into the generator answer
    foreach (pbit[i]) begin
      pg_in = 16'h0001 << pbit[i];
      ask(ssr_pkg::OP_MOD_COND_Q, 16'h0000, pg_in, 2'b10, "generator");
    end
    host.select(16'h0001, 1'b1, r);
    syn_in = 16'h0001;
    ask(ssr_pkg::OP_MOD_COND_Q, 16'h0000, 16'h0001, 2'b10, "synthesizer");
    // module latch and filters: rise caught, then falling-only
    ask(ssr_pkg::OP_MOD_EVENT_Q, 16'h0000, 16'h0001, 2'b10, "synth event");
    ask(ssr_pkg::OP_MOD_PTR_W, 16'h0000, 16'h0000, 2'b00, "module rise");
    ask(ssr_pkg::OP_MOD_NTR_W, 16'h0001, 16'h0000, 2'b00, "module fall");
    ask(ssr_pkg::OP_MOD_PTR_Q, 16'h0000, 16'h0000, 2'b10, "module rise");
    ask(ssr_pkg::OP_MOD_NTR_Q, 16'h0000, 16'h0001, 2'b10, "module fall");
    syn_in = 16'h0000;
    tick();
    ask(ssr_pkg::OP_MOD_EVENT_Q, 16'h0000, 16'h0001, 2'b10, "synth fall");
    ask(ssr_pkg::OP_MOD_EVENT_Q, 16'h0000, 16'h0000, 2'b10, "synth reread");
    stop_test();
  end
endmodule : test_status_event_register_model
